// *** mtwc_ctrl.sv ***
// Purpose: tag match, wake control/status, checksum engine control
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes: frame logic outside drives the rx strobes on mclk_in
`timescale 1ns/10ps
`default_nettype none
`include "mtwc_params.svh"
module mtwc_ctrl (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic soft_rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire mtwc_pkg::mtwc_rxev_t rxev_in,
  input wire logic [15:0] type_field_in,
  input wire logic type_valid_in,
  input wire logic [2:0] filt_idx_in,
  output logic [31:0] filt_word_out,
  output mtwc_pkg::mtwc_ctrl_t ctrl_out,
  output logic first_tag_hit_out,
  output logic second_tag_hit_out,
  output logic [10:0] max_frame_len_out,
  output logic [7:0] rx_checksum_start_out,
  output logic wake_out
);
  import mtwc_pkg::*;

  logic [15:0] first_tag_value_q;
  logic [15:0] second_tag_value_q;
  logic [31:0] wcsr_q;
  logic [31:0] coe_q;
  logic [31:0] wcsr_d;
  logic ph_wr_q;
  logic ph_rd_q;
  logic [3:0] ph_idx_q;
  logic [31:0] rdata_q;
  logic tagged_q;
  logic wake_q;
  logic addr_ok_w;
  logic take_w;
  logic [3:0] idx_w;
  logic hit1_w;
  logic hit2_w;
  logic filt_wr_w;
  logic wr_tag1_w;
  logic wr_tag2_w;
  logic wr_wcsr_w;
  logic wr_coe_w;
  logic [31:0] rd_mux_w;
  logic unicast_w;

  // address phase decode; only word offsets 0x00..0x3f hit this block
  assign take_w = hsel_in && hready_in && htrans_in[1];
  assign addr_ok_w = (haddr_in[31:6] == 26'h0) && (haddr_in[1:0] == 2'b00);
  assign idx_w = haddr_in[5:2];

  // capture the address phase for the data phase that follows
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ph_wr_q <= 1'b0;
      ph_rd_q <= 1'b0;
      ph_idx_q <= 4'h0;
    end else begin
      ph_wr_q <= take_w && hwrite_in && addr_ok_w;
      ph_rd_q <= take_w && !hwrite_in && addr_ok_w;
      ph_idx_q <= idx_w;
    end
  end

  // data phase write strobes
  assign wr_tag1_w = ph_wr_q && (ph_idx_q == `MTWC_IDX_TAG1);
  assign wr_tag2_w = ph_wr_q && (ph_idx_q == `MTWC_IDX_TAG2);
  assign wr_wcsr_w = ph_wr_q && (ph_idx_q == `MTWC_IDX_WCSR);
  assign wr_coe_w = ph_wr_q && (ph_idx_q == `MTWC_IDX_COE);
  assign filt_wr_w = ph_wr_q && (ph_idx_q == `MTWC_IDX_WFILT);

  // zero wait states; response always OKAY
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  assign rd_mux_w =
    (idx_w == `MTWC_IDX_TAG1) ? {16'h0000, first_tag_value_q} :
    (idx_w == `MTWC_IDX_TAG2) ? {16'h0000, second_tag_value_q} :
    (idx_w == `MTWC_IDX_WCSR) ? (wcsr_q & `MTWC_WCSR_MASK) :
    (idx_w == `MTWC_IDX_COE) ? (coe_q & `MTWC_COE_MASK) :
    32'h0000_0000; // filter port and unmapped words read zero

  // read data registered at the address phase, held through data phase
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (take_w && !hwrite_in) begin
      rdata_q <= addr_ok_w ? rd_mux_w : 32'h0000_0000;
    end
  end
  assign hrdata_out = rdata_q;

  // tag registers; soft reset returns them to default
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      first_tag_value_q <= 16'h0000;
      second_tag_value_q <= 16'h0000;
    end else if (soft_rst_in) begin
      first_tag_value_q <= 16'h0000;
      second_tag_value_q <= 16'h0000;
    end else begin
      if (wr_tag1_w) first_tag_value_q <= hwdata_in[15:0];
      if (wr_tag2_w) second_tag_value_q <= hwdata_in[15:0];
    end
  end

  // magic flag set wins over clear, written one clears it
  always_comb begin
    wcsr_d = wcsr_q;
    if (wr_wcsr_w) begin
      wcsr_d = hwdata_in & `MTWC_WCSR_MASK;
      wcsr_d[`MTWC_BIT_WFSEEN] = wcsr_q[`MTWC_BIT_WFSEEN] &
                                 !hwdata_in[`MTWC_BIT_WFSEEN];
      wcsr_d[`MTWC_BIT_MPSEEN] = wcsr_q[`MTWC_BIT_MPSEEN] &
                                 !hwdata_in[`MTWC_BIT_MPSEEN];
    end
    if (rxev_in.wake_frame_ok && wcsr_q[`MTWC_BIT_WFEN])
      wcsr_d[`MTWC_BIT_WFSEEN] = 1'b1;
    if (rxev_in.magic_ok && wcsr_q[`MTWC_BIT_MAGIC_PACKET_WAKE_EN])
      wcsr_d[`MTWC_BIT_MPSEEN] = 1'b1;
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wcsr_q <= `MTWC_RST_WORD;
    end else if (soft_rst_in) begin
      wcsr_q <= `MTWC_RST_WORD;
    end else begin
      wcsr_q <= wcsr_d;
    end
  end

  // engine control bits stored as written
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      coe_q <= `MTWC_RST_WORD;
    end else if (soft_rst_in) begin
      coe_q <= `MTWC_RST_WORD;
    end else if (wr_coe_w) begin
      coe_q <= hwdata_in & `MTWC_COE_MASK;
    end
  end

  assign ctrl_out.tx_checksum_engine_on = coe_q[`MTWC_BIT_TXCOE];
  assign ctrl_out.rx_checksum_engine_on = coe_q[`MTWC_BIT_RXCOE];
  assign ctrl_out.rx_checksum_start_mode = coe_q[`MTWC_BIT_RXMODE];
  assign ctrl_out.wake_frame_detect_en = wcsr_q[`MTWC_BIT_WFEN];
  assign ctrl_out.magic_packet_wake_en = wcsr_q[`MTWC_BIT_MAGIC_PACKET_WAKE_EN];
  assign ctrl_out.global_unicast_wake_en = wcsr_q[`MTWC_BIT_GUE];

  // start offset; in L3 mode the engine adjusts per frame (zero)
  assign rx_checksum_start_out = coe_q[`MTWC_BIT_RXMODE] ? 8'h00 :
                                 `MTWC_RX_START_PLAIN;

  mtwc_tag_cmp u_cmp1 (
    .tag_value_in(first_tag_value_q),
    .type_field_in(type_field_in),
    .match_out(hit1_w)
  );
  mtwc_tag_cmp u_cmp2 (
    .tag_value_in(second_tag_value_q),
    .type_field_in(type_field_in),
    .match_out(hit2_w)
  );

  // tagged state held for the frame, cleared at the next frame start
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tagged_q <= 1'b0;
      first_tag_hit_out <= 1'b0;
      second_tag_hit_out <= 1'b0;
    end else if (rxev_in.frame_start) begin
      tagged_q <= 1'b0;
      first_tag_hit_out <= 1'b0;
      second_tag_hit_out <= 1'b0;
    end else if (type_valid_in) begin
      tagged_q <= hit1_w || hit2_w;
      first_tag_hit_out <= hit1_w;
      second_tag_hit_out <= hit2_w;
    end
  end
  assign max_frame_len_out = tagged_q ? `MTWC_MAX_LEN_TAG : `MTWC_MAX_LEN;

  assign unicast_w = rxev_in.frame_start && !rxev_in.dest_bit0 &&
                     wcsr_q[`MTWC_BIT_GUE];
  // wake request held until software writes the wake register or a reset clears it
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wake_q <= 1'b0;
    end else if (soft_rst_in) begin
      wake_q <= 1'b0;
    end else if (unicast_w || (wcsr_d[`MTWC_BIT_WFSEEN] &&
                 !wcsr_q[`MTWC_BIT_WFSEEN]) ||
                 (wcsr_d[`MTWC_BIT_MPSEEN] && !wcsr_q[`MTWC_BIT_MPSEEN])) begin
      wake_q <= 1'b1;
    end else if (wr_wcsr_w) begin
      wake_q <= 1'b0;
    end
  end
  assign wake_out = wake_q;

  mtwc_filter_mem #(
    .WORDS(`MTWC_FILT_WORDS)
  ) u_filt (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .soft_rst_in(soft_rst_in),
    .wr_in(filt_wr_w),
    .wdata_in(hwdata_in),
    .rd_idx_in(filt_idx_in),
    .rd_word_out(filt_word_out),
    .ptr_out()
  );

  len_tag_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (type_valid_in && !rxev_in.frame_start && (hit1_w || hit2_w))
    |=> max_frame_len_out == 11'd1522)
    else $error("tagged frame length not raised");
  first_hit_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (type_valid_in && !rxev_in.frame_start && first_tag_value_q != 16'h0 &&
     type_field_in == first_tag_value_q) |=> first_tag_hit_out)
    else $error("first tag match missed");
  second_hit_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (type_valid_in && !rxev_in.frame_start && second_tag_value_q != 16'h0 &&
     type_field_in == second_tag_value_q) |=> second_tag_hit_out)
    else $error("second tag match missed");
  magic_set_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (rxev_in.magic_ok && wcsr_q[1] && !soft_rst_in) |=> wcsr_q[5])
    else $error("magic flag not set");
  wframe_set_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (rxev_in.wake_frame_ok && wcsr_q[2] && !soft_rst_in) |=> wcsr_q[6])
    else $error("wake frame flag not set");
  unicast_wake_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (unicast_w && !soft_rst_in) |=> wake_out)
    else $error("unicast wake missed");
  tx_engine_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (wr_coe_w && !soft_rst_in)
    |=> ctrl_out.tx_checksum_engine_on == $past(hwdata_in[16]))
    else $error("tx engine enable mismatch");
  rx_engine_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (wr_coe_w && !soft_rst_in)
    |=> ctrl_out.rx_checksum_engine_on == $past(hwdata_in[0]))
    else $error("rx engine enable mismatch");
  resv_zero_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (take_w && !hwrite_in && idx_w == `MTWC_IDX_COE)
    |=> hrdata_out[31:17] == 15'h0)
    else $error("reserved bits read nonzero");
  start_off_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !coe_q[1] |-> rx_checksum_start_out == 8'd14)
    else $error("plain start offset wrong");
  start_l3_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    coe_q[1] |-> rx_checksum_start_out == 8'h00)
    else $error("l3 start offset wrong");
  len_plain_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !tagged_q |-> max_frame_len_out == 11'd1518)
    else $error("untagged frame length wrong");
  first_miss_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (type_valid_in && !rxev_in.frame_start &&
     type_field_in != first_tag_value_q) |=> !first_tag_hit_out)
    else $error("false first tag hit");
  second_miss_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (type_valid_in && !rxev_in.frame_start &&
     type_field_in != second_tag_value_q) |=> !second_tag_hit_out)
    else $error("false second tag hit");
  wcsr_resv_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (take_w && !hwrite_in && idx_w == `MTWC_IDX_WCSR)
    |=> (hrdata_out & ~`MTWC_WCSR_MASK) == 32'h0)
    else $error("wake reserved bits read nonzero");
  filt_rd_zero_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (take_w && !hwrite_in && idx_w == `MTWC_IDX_WFILT)
    |=> hrdata_out == 32'h0)
    else $error("filter port read nonzero");
  magic_clr_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (wr_wcsr_w && hwdata_in[5] && !(rxev_in.magic_ok && wcsr_q[1]))
    |=> !wcsr_q[5])
    else $error("magic flag not cleared");
  wframe_clr_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (wr_wcsr_w && hwdata_in[6] && !(rxev_in.wake_frame_ok && wcsr_q[2]))
    |=> !wcsr_q[6])
    else $error("wake frame flag not cleared");
  // no wake frame flag while disabled
  wframe_off_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (!wcsr_q[6] && !wcsr_q[2]) |=> !wcsr_q[6])
    else $error("wake frame flag set while disabled");
  magic_off_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (!wcsr_q[5] && !wcsr_q[1]) |=> !wcsr_q[5])
    else $error("magic flag set while disabled");
  // tx engine holds without a write
  tx_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (!wr_coe_w && !soft_rst_in)
    |=> $stable(ctrl_out.tx_checksum_engine_on))
    else $error("tx engine enable changed unwritten");

  filt_write_c: cover property (@(posedge mclk_in) filt_wr_w);
  tagged_c: cover property (@(posedge mclk_in) tagged_q);
  magic_c: cover property (@(posedge mclk_in) wcsr_q[5]);
  wake_c: cover property (@(posedge mclk_in) wake_out);
  // engine bits both on at once
  coe_both_c: cover property (@(posedge mclk_in)
    coe_q[`MTWC_BIT_TXCOE] && coe_q[`MTWC_BIT_RXCOE]);
endmodule
`default_nettype wire

// *** mtwc_params.svh ***
// Purpose: constants for the tag, wake and checksum control registers
// Assumes: word-indexed offsets, byte address is four times the index
// Notes: all numbers live here; the package holds the types
//
// Overview of operation
// - first tag value compared with frame bytes 13-14
// - second tag value compared with frame bytes 13-14
// - tagged frames allow 1522 instead of 1518
// - first filter write after reset hits word zero
// - filter pointer wraps after eight words
// - unicast wake on destination bit zero clear
// - wake frame received sets flag bit 6
// - magic packet received sets flag bit 5
// - wake frame enable bit 2 arms filter detection
// - magic packet enable bit 1 arms magic mode
// - control bit 16 enables transmit checksum engine
// - mode bit picks start at 14 or L3
// - control bit 0 enables receive checksum engine
`ifndef MTWC_PARAMS_SVH
`define MTWC_PARAMS_SVH
`define MTWC_IDX_TAG1 4'h9
`define MTWC_IDX_TAG2 4'ha
`define MTWC_IDX_WFILT 4'hb
`define MTWC_IDX_WCSR 4'hc
`define MTWC_IDX_COE 4'hd
`define MTWC_RST_WORD 32'h0000_0000
`define MTWC_TAG_MASK 32'h0000_ffff
`define MTWC_WCSR_MASK 32'h0000_0266
`define MTWC_COE_MASK 32'h0001_0003
`define MTWC_BIT_GUE 9
`define MTWC_BIT_WFSEEN 6
`define MTWC_BIT_MPSEEN 5
`define MTWC_BIT_WFEN 2
`define MTWC_BIT_MAGIC_PACKET_WAKE_EN 1
`define MTWC_BIT_TXCOE 16
`define MTWC_BIT_RXMODE 1
`define MTWC_BIT_RXCOE 0
`define MTWC_MAX_LEN 11'd1518
`define MTWC_MAX_LEN_TAG 11'd1522
`define MTWC_RX_START_PLAIN 8'd14
`define MTWC_FILT_WORDS 8
`endif

// *** mtwc_pkg.sv ***
// Purpose: types for the tag, wake and checksum control block
// Assumes: nothing beyond the params header
// Notes: structs carry the control outputs and frame strobes
package mtwc_pkg;
  // decoded register controls
  typedef struct packed {
    logic tx_checksum_engine_on;
    logic rx_checksum_engine_on;
    logic rx_checksum_start_mode;
    logic wake_frame_detect_en;
    logic magic_packet_wake_en;
    logic global_unicast_wake_en;
  } mtwc_ctrl_t;
  // receive-side event strobes from the frame logic
  typedef struct packed {
    logic magic_ok;
    logic wake_frame_ok;
    logic frame_start;
    logic dest_bit0;
  } mtwc_rxev_t;
endpackage

// *** mtwc_tag_cmp.sv ***
// Purpose: compare one tag value with frame bytes thirteen and fourteen
// Assumes: type field presented once the two bytes are in
// Notes: a zero tag value never matches, so an unused register is idle
`timescale 1ns/10ps
`default_nettype none
module mtwc_tag_cmp (
  input wire logic [15:0] tag_value_in,
  input wire logic [15:0] type_field_in,
  output logic match_out
);
  // zero guard keeps untouched registers from flagging untagged frames
  assign match_out = (tag_value_in != 16'h0000) &&
                     (tag_value_in == type_field_in);
endmodule
`default_nettype wire

// *** mtwc_filter_mem.sv ***
// Purpose: write-only wake-up filter store with auto-increment pointer
// Assumes: one write strobe per bus write to the filter port
// Notes: contents are read by the external filter matcher only
`timescale 1ns/10ps
`default_nettype none
`include "mtwc_params.svh"
module mtwc_filter_mem #(
  parameter int WORDS = `MTWC_FILT_WORDS
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic soft_rst_in,
  input wire logic wr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [$clog2(WORDS)-1:0] rd_idx_in,
  output logic [31:0] rd_word_out,
  output logic [$clog2(WORDS)-1:0] ptr_out
);
  localparam int PW = $clog2(WORDS);
  logic [31:0] mem_q [WORDS];
  logic [PW-1:0] ptr_q;
  logic [PW-1:0] ptr_d;
  logic last_w;

  // depth must be a power of two so the pointer wraps by itself
  if (WORDS < 2 || (1 << PW) != WORDS) begin : g_depth_chk
    $error("filter depth must be a power of two");
  end

  assign last_w = (ptr_q == PW'(WORDS - 1));
  assign ptr_d = last_w ? '0 : ptr_q + 1'b1;
  assign ptr_out = ptr_q;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ptr_q <= '0;
    end else if (soft_rst_in) begin
      ptr_q <= '0;
    end else if (wr_in) begin
      ptr_q <= ptr_d;
    end
  end

  // storage needs no reset; matcher ignores it until software loads it
  always_ff @(posedge mclk_in) begin
    if (wr_in && !soft_rst_in) begin
      mem_q[ptr_q] <= wdata_in;
    end
  end

  // registered lookup port for the matcher
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_word_out <= 32'h0000_0000;
    end else begin
      rd_word_out <= mem_q[rd_idx_in];
    end
  end

  wrap_check_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (wr_in && !soft_rst_in && last_w) |=> ptr_q == '0)
    else $error("filter pointer failed to wrap");
  soft_zero_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    soft_rst_in |=> ptr_q == '0)
    else $error("filter pointer not cleared by soft reset");
endmodule
`default_nettype wire

// *** mtwc_frame_src.sv ***
// Purpose: receive-side frame source standing in for the network partner
// Assumes: one frame at a time, strobes launched just after a rising edge
// Notes: released type and destination fields show inverted data, never the last good value
`timescale 1ns/10ps
`default_nettype none
module mtwc_frame_src (
  input wire logic mclk_in,
  output mtwc_pkg::mtwc_rxev_t rxev_out,
  output logic [15:0] type_field_out,
  output logic type_valid_out
);
  import mtwc_pkg::*;

  // idle lines at time zero
  initial begin
    rxev_out = '0;
    type_field_out = 16'h0000;
    type_valid_out = 1'b0;
  end

  // one frame: start, type bytes, then the detector verdicts
  task automatic send(input logic [15:0] tf, input logic d0,
                      input logic mp, input logic wf);
    @(posedge mclk_in);
    rxev_out.frame_start <= 1'b1;
    rxev_out.dest_bit0 <= d0;
    @(posedge mclk_in);
    rxev_out.frame_start <= 1'b0;
    rxev_out.dest_bit0 <= ~d0;
    type_field_out <= tf;
    type_valid_out <= 1'b1;
    @(posedge mclk_in);
    type_valid_out <= 1'b0;
    type_field_out <= ~tf; // stale type must not be trusted
    rxev_out.magic_ok <= mp;
    rxev_out.wake_frame_ok <= wf;
    @(posedge mclk_in);
    rxev_out.magic_ok <= 1'b0;
    rxev_out.wake_frame_ok <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** mtwc_ctrl_test.sv ***
// Purpose: self-checking bench for the tag, wake and checksum controls
// Assumes: zero-wait AHB-Lite slave, frame source model on the rx side
// Notes: filter contents after soft reset are not assumed cleared
`timescale 1ns/10ps
`default_nettype none
`include "mtwc_params.svh"
`define TB_CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, (got), (exp)); \
  end \
end
module mtwc_ctrl_test;
  import mtwc_pkg::*;
  localparam logic [31:0] A_TAG1 = {26'h0, `MTWC_IDX_TAG1, 2'b00};
  localparam logic [31:0] A_TAG2 = {26'h0, `MTWC_IDX_TAG2, 2'b00};
  localparam logic [31:0] A_FILT = {26'h0, `MTWC_IDX_WFILT, 2'b00};
  localparam logic [31:0] A_WCSR = {26'h0, `MTWC_IDX_WCSR, 2'b00};
  localparam logic [31:0] A_COE = {26'h0, `MTWC_IDX_COE, 2'b00};
  localparam logic [31:0] A_NONE = 32'h0000_0038;
  logic [31:0] amap [6] = '{A_TAG1, A_TAG2, A_FILT, A_WCSR, A_COE, A_NONE};
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic soft_rst_in = 1'b0;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'b00;
  logic hwrite_in = 1'b0;
  logic [2:0] hsize_in = 3'b010;
  logic [31:0] hwdata_in = 32'h0;
  logic [2:0] filt_idx_in = 3'h0;
  logic [31:0] hrdata_out, filt_word_out, rdata;
  logic hreadyout_out, hresp_out, wake_out, hit1, hit2;
  logic [15:0] type_field;
  logic type_valid;
  logic [10:0] max_frame_len_out;
  logic [7:0] rx_checksum_start_out;
  mtwc_rxev_t rxev;
  mtwc_ctrl_t ctrl_out;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;

  // 10 MHz clock
  always #50 mclk_in = ~mclk_in;

  // hang guard, the whole sequence needs under two hundred cycles
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      end_of_test();
    end
  end

  mtwc_ctrl u_mtwc_ctrl (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .soft_rst_in(soft_rst_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .rxev_in(rxev),
    .type_field_in(type_field), .type_valid_in(type_valid),
    .filt_idx_in(filt_idx_in), .filt_word_out(filt_word_out),
    .ctrl_out(ctrl_out), .first_tag_hit_out(hit1),
    .second_tag_hit_out(hit2), .max_frame_len_out(max_frame_len_out),
    .rx_checksum_start_out(rx_checksum_start_out), .wake_out(wake_out)
  );
  mtwc_frame_src u_mtwc_frame_src (
    .mclk_in(mclk_in), .rxev_out(rxev), .type_field_out(type_field),
    .type_valid_out(type_valid)
  );

  // one AHB single word transfer, held until hready is sampled high
  task automatic xfer(input logic wr, input logic [31:0] addr,
                      input logic [31:0] wd);
    hsel_in <= 1'b1;
    haddr_in <= addr;
    htrans_in <= 2'b10;
    hwrite_in <= wr;
    hsize_in <= 3'b010;
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'b00;
    hwdata_in <= wd;
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    rdata = hrdata_out;
  endtask
  task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
    xfer(1'b1, addr, wd);
    #1;
  endtask
  task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
    xfer(1'b0, addr, 32'h0);
    `TB_CHK(rdata, exp)
    `TB_CHK(hresp_out, 1'b0)
  endtask
  // frame from the partner, outputs looked at once it has settled
  task automatic frame(input logic [15:0] tf, input logic d0,
                       input logic mp, input logic wf);
    u_mtwc_frame_src.send(tf, d0, mp, wf);
    @(posedge mclk_in);
    #1;
  endtask
  // filter word readback has one cycle of latency
  task automatic peek(input logic [2:0] i, input logic [31:0] exp);
    filt_idx_in <= i;
    repeat (2) @(posedge mclk_in);
    #1;
    `TB_CHK(filt_word_out, exp)
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge mclk_in);
    #1;
    `TB_CHK(max_frame_len_out, `MTWC_MAX_LEN)
    `TB_CHK(rx_checksum_start_out, `MTWC_RX_START_PLAIN)
    repeat (5) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    for (int i = 0; i < 6; i++) rd_chk(amap[i], `MTWC_RST_WORD);
    wr(A_TAG1, 32'hffff_ffff);
    rd_chk(A_TAG1, `MTWC_TAG_MASK);
    wr(A_NONE, 32'hffff_ffff);
    rd_chk(A_NONE, 32'h0000_0000);
    // software uses 0x8100 or leaves a tag register at zero
    wr(A_TAG1, 32'h0000_8100);
    frame(16'h8100, 1'b1, 1'b0, 1'b0);
    `TB_CHK({hit1, hit2}, 2'b10)
    `TB_CHK(max_frame_len_out, `MTWC_MAX_LEN_TAG)
    wr(A_TAG1, 32'h0000_0000);
    wr(A_TAG2, 32'h0000_8100);
    rd_chk(A_TAG2, 32'h0000_8100);
    frame(16'h8100, 1'b1, 1'b0, 1'b0);
    `TB_CHK({hit1, hit2}, 2'b01)
    `TB_CHK(max_frame_len_out, `MTWC_MAX_LEN_TAG)
    frame(16'h0800, 1'b1, 1'b0, 1'b0);
    `TB_CHK({hit1, hit2}, 2'b00)
    `TB_CHK(max_frame_len_out, `MTWC_MAX_LEN)
    // nine writes: the ninth wraps onto word zero
    for (int k = 0; k < 9; k++) wr(A_FILT, 32'h0f0f_0000 + 32'(k));
    peek(3'h0, 32'h0f0f_0008);
    for (int k = 1; k < 8; k++) peek(k[2:0], 32'h0f0f_0000 + 32'(k));
    rd_chk(A_FILT, 32'h0000_0000);
    wr(A_FILT, 32'hcafe_0001);
    peek(3'h1, 32'hcafe_0001);
    soft_rst_in <= 1'b1;
    @(posedge mclk_in);
    soft_rst_in <= 1'b0;
    rd_chk(A_TAG2, `MTWC_RST_WORD);
    wr(A_FILT, 32'h5a5a_0000);
    peek(3'h0, 32'h5a5a_0000);
    // wake control: enables, flags and the wake level
    wr(A_WCSR, 32'hffff_ffff);
    rd_chk(A_WCSR, 32'h0000_0206);
    `TB_CHK(ctrl_out[2:0], 3'b111)
    frame(16'h0800, 1'b1, 1'b1, 1'b0);
    `TB_CHK(wake_out, 1'b1)
    rd_chk(A_WCSR, 32'h0000_0226);
    wr(A_WCSR, 32'h0000_0226);
    `TB_CHK(wake_out, 1'b0)
    rd_chk(A_WCSR, 32'h0000_0206);
    frame(16'h0800, 1'b1, 1'b0, 1'b1);
    `TB_CHK(wake_out, 1'b1)
    rd_chk(A_WCSR, 32'h0000_0246);
    wr(A_WCSR, 32'h0000_0040);
    frame(16'h0800, 1'b1, 1'b1, 1'b1);
    `TB_CHK(wake_out, 1'b0)
    rd_chk(A_WCSR, 32'h0000_0000);
    wr(A_WCSR, 32'h0000_0200);
    frame(16'h0800, 1'b1, 1'b0, 1'b0);
    `TB_CHK(wake_out, 1'b0)
    frame(16'h0800, 1'b0, 1'b0, 1'b0);
    `TB_CHK(wake_out, 1'b1)
    // checksum bits change only with no frame traffic
    wr(A_COE, 32'hffff_ffff);
    rd_chk(A_COE, `MTWC_COE_MASK);
    `TB_CHK(ctrl_out[5:3], 3'b111)
    `TB_CHK(rx_checksum_start_out, 8'h00)
    wr(A_COE, 32'h0001_0000);
    `TB_CHK(ctrl_out[5:3], 3'b100)
    `TB_CHK(rx_checksum_start_out, `MTWC_RX_START_PLAIN)
    wr(A_COE, 32'h0000_0001);
    `TB_CHK(ctrl_out[5:3], 3'b010)
    end_of_test();
  end
endmodule
`default_nettype wire
